// ### src/cpfl_top.sv
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

// Contract
// - input overvoltage stops converter, auto resumes
// - input overvoltage sets fault code, interrupts
// - system overvoltage stops converter, enables sink
// - boost enable ramps output via soft-start
// - boost short retries seven times, then faults
// - boost fault cleared by boost re-enable
// - boost overvoltage disables boost, faults, interrupts
// - thermal regulation reduces current, flags status
// - buck shutdown cuts converter, switch; recovers
// - boost shutdown clears enable, switch recovers
// - battery overvoltage stops charge, flags, interrupts
// - depletion latches switch off until plug-in
// - recovery charges short, then precharge current
// - overcurrent latches switch off until ship exit
// - low battery: linear switch, status bit
// - charge off or done: system tracks battery
// - input limit reduces charge current
// - input limit status bits follow limiting
// - zero charge, low system: supplement mode
// - supplement holds drop, exits on depletion
// - each event gives one 256 us pulse, none while a pulse runs
// - faults held, interrupt blocked until read
module cpfl_top
  import cpfl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire cpfl_pkg::cpfl_cmp_t i_cmp,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output cpfl_pkg::cpfl_ctl_t o_ctl,
  output logic o_int_n
);
  import cpfl_pkg::*;

  logic [CMP_W-1:0] cmp_clean;  // deglitched flags
  cpfl_cmp_t c;                 // same flags as a struct
  cpfl_cmp_t c_prev_q;          // previous value, for edge detection
  logic int_fire;               // one-cycle interrupt request
  logic int_busy;               // pulse in progress
  logic int_n_raw;              // pulse generator output

  // register state
  logic [31:0] ctrl_q, ctrl_d;          // software controls
  logic [1:0] chg_fault_q, chg_fault_d; // charge fault field
  logic boost_fault_q, boost_fault_d;   // boost fault flag
  logic battery_fault_flag_q, battery_fault_flag_d;       // battery fault flag
  logic fault_hold_q, fault_hold_d;     // capture held until fault read
  logic dep_latch_q, dep_latch_d;       // overdischarge latch
  logic oc_latch_q, oc_latch_d;         // overcurrent latch
  logic shut_q, shut_d;                 // thermal shutdown in force
  logic supp_q, supp_d;                 // supplement mode
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  cpfl_ctl_t ctl_q, ctl_d;
  logic int_n_q;

  // boost supervisor state
  cpfl_bst_t bst_q, bst_d;
  logic [2:0] retry_q, retry_d;  // retries spent
  logic [7:0] bcnt_q, bcnt_d;    // ramp level or retry gap timer

  // register access decode, used only for the error response of reads and writes
  function automatic logic is_reg(input logic [11:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_FAULT) || (a == ADDR_STATUS);
  endfunction

  cpfl_deglitch u_deglitch (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_raw(i_cmp),
    .o_clean(cmp_clean)
  );

  assign c = cmp_clean;

  cpfl_int_pulse u_int (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_fire(int_fire),
    .o_int_n(int_n_raw),
    .o_busy(int_busy)
  );

  logic apb_acc;     // access phase, answered next cycle
  logic wr_ctrl;     // control register write
  logic rd_fault;    // fault register read
  logic boost_rise;  // software set boost enable
  logic ev_in_ov, ev_shut_buck, ev_bat_ov, ev_boost_fail, ev_boost_ov;
  logic ev_other;    // non-fault interrupt events
  logic boost_mode;

  // event detection on flag edges; boost faults on levels while in ramp or run
  always_comb
  begin
    apb_acc = i_psel && i_penable && !pready_q;
    wr_ctrl = apb_acc && i_pwrite && (i_paddr == ADDR_CTRL);
    rd_fault = apb_acc && !i_pwrite && (i_paddr == ADDR_FAULT);
    boost_rise = wr_ctrl && i_pwdata[CTRL_BOOST_EN] && !ctrl_q[CTRL_BOOST_EN];
    boost_mode = (bst_q != BST_OFF);
    ev_in_ov = c.in_ov && !c_prev_q.in_ov;
    ev_shut_buck = c.temp_shut && !c_prev_q.temp_shut && !boost_mode;
    ev_bat_ov = c.bat_ov && !c_prev_q.bat_ov;
    ev_boost_ov = (bst_q == BST_RUN || bst_q == BST_RAMP) && c.boost_ov;
    ev_boost_fail = (bst_q == BST_RUN || bst_q == BST_RAMP) && c.boost_short
                    && (retry_q == BOOST_RETRY_MAX);
    ev_other = (c.chg_done && !c_prev_q.chg_done)
               || (c.in_present && !c_prev_q.in_present)
               || (!c.in_present && c_prev_q.in_present)
               || (ctrl_q[CTRL_DPM_INT_EN]
                   && ((c.in_ilim && !c_prev_q.in_ilim)
                       || (c.in_vlim && !c_prev_q.in_vlim)));
  end

  // boost supervisor: soft-start, short retries, overvoltage and thermal exit
  always_comb
  begin
    bst_d = bst_q;
    retry_d = retry_q;
    bcnt_d = bcnt_q;
    case (bst_q)
      BST_OFF:
      begin
        if (ctrl_q[CTRL_BOOST_EN] && !c.temp_shut)
        begin
          bst_d = BST_RAMP;
          bcnt_d = 8'h0;
          retry_d = 3'h0;
        end
      end
      BST_RAMP:
      begin
        if (bcnt_q == BOOST_SS_STEPS)
          bst_d = BST_RUN;
        else
          bcnt_d = bcnt_q + 8'h1;
      end
      BST_RUN:
      begin
        bcnt_d = BOOST_SS_STEPS;
      end
      BST_RETRY:
      begin
        // boost stays off through the gap so a hard short cools down
        if (bcnt_q == BOOST_RETRY_GAP)
        begin
          bst_d = BST_RAMP;
          bcnt_d = 8'h0;
        end
        else
          bcnt_d = bcnt_q + 8'h1;
      end
      default:
      begin
        bst_d = BST_OFF;
      end
    endcase
    if ((bst_q == BST_RAMP || bst_q == BST_RUN) && c.boost_short)
    begin
      bst_d = BST_RETRY;
      bcnt_d = 8'h0;
      retry_d = retry_q + 3'h1;
    end
    if (!ctrl_q[CTRL_BOOST_EN] || ev_boost_fail || ev_boost_ov || c.temp_shut)
    begin
      bst_d = BST_OFF;
      bcnt_d = 8'h0;
    end
  end

  // control register, fault capture and protection latches
  always_comb
  begin
    ctrl_d = ctrl_q;
    chg_fault_d = chg_fault_q;
    boost_fault_d = boost_fault_q;
    battery_fault_flag_d = battery_fault_flag_q;
    fault_hold_d = fault_hold_q;
    dep_latch_d = dep_latch_q;
    oc_latch_d = oc_latch_q;
    shut_d = shut_q;
    supp_d = supp_q;
    int_fire = 1'b0;
    if (wr_ctrl)
      ctrl_d = i_pwdata & 32'h0000_0007;
    // hardware clears the boost enable on fault or shutdown
    if (ev_boost_fail || ev_boost_ov || (boost_mode && c.temp_shut))
      ctrl_d[CTRL_BOOST_EN] = 1'b0;
    // a fault read releases the capture and reloads what stands now; sets below still win
    if (rd_fault)
    begin
      fault_hold_d = 1'b0;
      chg_fault_d = c.in_ov ? FAULT_INPUT
                    : ((c.temp_shut && !boost_mode) ? FAULT_THERMAL : FAULT_NONE);
      battery_fault_flag_d = c.bat_ov;
    end
    if (boost_rise)
      boost_fault_d = 1'b0;
    if (!fault_hold_q || rd_fault)
    begin
      if (ev_in_ov)
        chg_fault_d = FAULT_INPUT;
      else if (ev_shut_buck)
        chg_fault_d = FAULT_THERMAL;
      if (ev_bat_ov)
        battery_fault_flag_d = 1'b1;
      if (ev_boost_fail || ev_boost_ov)
        boost_fault_d = 1'b1;
      if (ev_in_ov || ev_shut_buck || ev_bat_ov || ev_boost_fail || ev_boost_ov)
      begin
        fault_hold_d = 1'b1;
        int_fire = 1'b1;
      end
    end
    if (ev_other && !int_busy)
      int_fire = 1'b1;
    // thermal shutdown with hysteresis
    if (c.temp_shut)
      shut_d = 1'b1;
    else if (c.temp_cool)
      shut_d = 1'b0;
    // overdischarge latch, set unpowered or in supplement, released only by a plug-in
    if (c.bat_depl && (!c.in_present || supp_q))
      dep_latch_d = 1'b1;
    else if (c.in_present && !c_prev_q.in_present)
      dep_latch_d = 1'b0;
    // overcurrent latch, released only by a shipping-mode exit
    if (c.bat_oc)
      oc_latch_d = 1'b1;
    else if (c.ship_exit)
      oc_latch_d = 1'b0;
    // supplement entry and exit
    if (c.bat_depl)
      supp_d = 1'b0;
    else if (c.chg_zero && c.sys_below_bat && c.in_present)
      supp_d = 1'b1;
    else if (!c.sys_below_bat)
      supp_d = 1'b0;
  end

  // power stage and regulation outputs
  always_comb
  begin
    ctl_d = '0;
    ctl_d.conv_on = c.in_present && !c.in_ov && !c.sys_ov && !shut_q
                    && !boost_mode;
    ctl_d.sys_sink = c.sys_ov;
    ctl_d.batsw_on = !shut_q && !dep_latch_q && !oc_latch_q;
    ctl_d.chg_on = ctrl_q[CTRL_CHG_EN] && !c.bat_ov && !shut_q
                   && c.in_present && !c.in_ov;
    ctl_d.batsw_linear = ctl_d.batsw_on && c.bat_below_min;
    ctl_d.sys_track_min = c.bat_below_min;
    ctl_d.sys_track_bat = !c.bat_below_min
                          && (!ctrl_q[CTRL_CHG_EN] || c.chg_done);
    ctl_d.chg_reduce = c.temp_reg || c.in_ilim || c.in_vlim;
    ctl_d.term_block = ctl_d.chg_reduce;
    ctl_d.timer_half = ctl_d.chg_reduce;
    ctl_d.batsw_vds_reg = supp_q && ctl_d.batsw_on;
    ctl_d.boost_on = (bst_q == BST_RAMP || bst_q == BST_RUN);
    ctl_d.boost_ramp = bcnt_q;
    if (c.bat_short)
      ctl_d.ichg_sel = 2'h2;
    else if (c.bat_low)
      ctl_d.ichg_sel = 2'h1;
    else
      ctl_d.ichg_sel = 2'h0;
  end

  // apb slave: one wait state, so every access answers on its second access edge
  always_comb
  begin
    pready_d = apb_acc;
    pslverr_d = apb_acc && !is_reg(i_paddr);
    prdata_d = 32'h0000_0000;
    if (apb_acc && !i_pwrite)
    begin
      case (i_paddr)
        ADDR_CTRL: prdata_d = ctrl_q;
        ADDR_FAULT: prdata_d = {28'h000_0000, battery_fault_flag_q, boost_fault_q, chg_fault_q};
        ADDR_STATUS: prdata_d = {24'h00_0000, supp_q, dep_latch_q, oc_latch_q,
                                 c.in_ilim, c.in_vlim,
                                 c.bat_below_min, c.temp_reg,
                                 shut_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // registers
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ctrl_q <= CTRL_RESET;
      chg_fault_q <= FAULT_NONE;
      boost_fault_q <= 1'b0;
      battery_fault_flag_q <= 1'b0;
      fault_hold_q <= 1'b0;
      dep_latch_q <= 1'b0;
      oc_latch_q <= 1'b0;
      shut_q <= 1'b0;
      supp_q <= 1'b0;
      bst_q <= BST_OFF;
      retry_q <= 3'h0;
      bcnt_q <= 8'h0;
      c_prev_q <= '0;
      ctl_q <= '0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      int_n_q <= 1'b1;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      chg_fault_q <= chg_fault_d;
      boost_fault_q <= boost_fault_d;
      battery_fault_flag_q <= battery_fault_flag_d;
      fault_hold_q <= fault_hold_d;
      dep_latch_q <= dep_latch_d;
      oc_latch_q <= oc_latch_d;
      shut_q <= shut_d;
      supp_q <= supp_d;
      bst_q <= bst_d;
      retry_q <= retry_d;
      bcnt_q <= bcnt_d;
      c_prev_q <= c;
      ctl_q <= ctl_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      int_n_q <= int_n_raw;
    end
  end

  assign o_ctl = ctl_q;
  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_int_n = int_n_q;

endmodule

// ### common/cpfl_pkg.sv
package cpfl_pkg;

  // clock rate and interrupt pulse width
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned INT_PULSE_US = 256;
  localparam int unsigned INT_PULSE_CYC = (CLK_HZ / 1_000_000) * INT_PULSE_US;

  // comparator deglitch length in cycles
  localparam int unsigned DEGLITCH_CYC = 8;

  // boost short-circuit retry budget
  localparam logic [2:0] BOOST_RETRY_MAX = 3'h7;
  // off time between boost retries, and soft-start ramp length, in cycles
  localparam logic [7:0] BOOST_RETRY_GAP = 8'h40;
  localparam logic [7:0] BOOST_SS_STEPS = 8'hFF;

  // charge fault field codes
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_INPUT = 2'h1;
  localparam logic [1:0] FAULT_THERMAL = 2'h2;

  // apb register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FAULT = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // control register field positions
  localparam int unsigned CTRL_BOOST_EN = 0;
  localparam int unsigned CTRL_CHG_EN = 1;
  localparam int unsigned CTRL_DPM_INT_EN = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

  // fault register field positions
  localparam int unsigned FLT_CHG_LSB = 0;
  localparam int unsigned FLT_BOOST = 2;
  localparam int unsigned FLT_BAT = 3;

  // raw comparator flags from the analog side
  typedef struct packed {
    logic in_ov;        // input above overvoltage threshold
    logic sys_ov;       // system 350 mV above minimum level
    logic boost_short;  // boost output shorted
    logic boost_ov;     // boost output above its overvoltage threshold
    logic temp_reg;     // junction above 110 C
    logic temp_shut;    // junction above 160 C
    logic temp_cool;    // junction 30 C below shutdown point
    logic bat_ov;       // battery 4% above regulation target
    logic bat_depl;     // battery below depletion threshold
    logic bat_oc;       // discharge above battery switch current limit
    logic bat_short;    // battery below short threshold
    logic bat_low;      // battery below low-battery threshold
    logic bat_below_min;// battery below minimum system setting
    logic in_ilim;      // input current above its limit
    logic in_vlim;      // input voltage below its limit
    logic sys_below_bat;// system below battery voltage
    logic chg_zero;     // charge current at zero
    logic in_present;   // input source plugged in
    logic chg_done;     // charge terminated
    logic ship_exit;    // shipping-mode exit event
  } cpfl_cmp_t;

  localparam int unsigned CMP_W = $bits(cpfl_cmp_t);

  // power stage and regulation controls
  typedef struct packed {
    logic conv_on;        // converter may switch
    logic sys_sink;       // system discharge sink on
    logic batsw_on;       // battery switch on
    logic batsw_linear;   // battery switch in linear mode
    logic batsw_vds_reg;  // battery switch gate holds minimum drop
    logic chg_on;         // charging allowed
    logic chg_reduce;     // lower charge current
    logic term_block;     // charge termination suppressed
    logic timer_half;     // safety timer at half rate
    logic sys_track_bat;  // system held just above battery
    logic sys_track_min;  // system held above minimum setting
    logic boost_on;       // boost switching
    logic [7:0] boost_ramp; // soft-start level
    logic [1:0] ichg_sel; // 0 fast, 1 precharge, 2 short current
  } cpfl_ctl_t;

  // boost supervisor states
  typedef enum logic [2:0] {
    BST_OFF,
    BST_RAMP,
    BST_RUN,
    BST_RETRY
  } cpfl_bst_t;

endpackage

// ### src/cpfl_deglitch.sv
`timescale 1ns/1ps

// two-flop synchroniser then a stable-count filter per flag
module cpfl_deglitch
  import cpfl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [CMP_W-1:0] i_raw,
  output logic [CMP_W-1:0] o_clean
);

  logic [CMP_W-1:0] meta_q;  // first stage, read only by sync_q
  logic [CMP_W-1:0] sync_q;  // second stage
  logic [CMP_W-1:0] clean_q, clean_d;
  logic [3:0] cnt_q [CMP_W];
  logic [3:0] cnt_d [CMP_W];

  // a flag only moves after it has held its new level for the whole window
  always_comb
  begin
    clean_d = clean_q;
    for (int i = 0; i < CMP_W; i++)
    begin
      cnt_d[i] = 4'h0;
      if (sync_q[i] != clean_q[i])
      begin
        if (cnt_q[i] == 4'(DEGLITCH_CYC - 1))
          clean_d[i] = sync_q[i];
        else
          cnt_d[i] = cnt_q[i] + 4'h1;
      end
    end
  end

  // registers only
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
      clean_q <= '0;
      for (int i = 0; i < CMP_W; i++)
        cnt_q[i] <= 4'h0;
    end
    else
    begin
      meta_q <= i_raw;
      sync_q <= meta_q;
      clean_q <= clean_d;
      for (int i = 0; i < CMP_W; i++)
        cnt_q[i] <= cnt_d[i];
    end
  end

  assign o_clean = clean_q;

endmodule

// ### src/cpfl_int_pulse.sv
`timescale 1ns/1ps

// stretches a one-cycle request into a fixed active-low interrupt pulse
module cpfl_int_pulse
  import cpfl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_fire,
  output logic o_int_n,
  output logic o_busy
);

  logic [13:0] cnt_q, cnt_d;
  logic int_n_q, int_n_d;

  // requests arriving during a pulse are merged into it
  always_comb
  begin
    cnt_d = cnt_q;
    int_n_d = int_n_q;
    if (cnt_q != 14'h0)
    begin
      cnt_d = cnt_q - 14'h1;
      int_n_d = (cnt_q == 14'h1);
    end
    else if (i_fire)
    begin
      cnt_d = 14'(INT_PULSE_CYC);
      int_n_d = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      cnt_q <= 14'h0;
      int_n_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      int_n_q <= int_n_d;
    end
  end

  assign o_int_n = int_n_q;
  assign o_busy = (cnt_q != 14'h0);

endmodule

// ### tb/cpfl_host_model.sv
`timescale 1ns/1ps

// host side: apb master plus the host's habits with fault and boost bits
module cpfl_host_model
  import cpfl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata
);
  // bus idle from time zero
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0000_0000;
  end

  // one transfer; request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge i_ref_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= wd;
    @(posedge i_ref_clk);
    o_penable <= 1'b1;
    // no cycle count assumed; only the bench watchdog ends a hung wait
    do
    begin
      @(posedge i_ref_clk);
    end
    while (i_pready !== 1'b1);
    rd = i_prdata;
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask

  // first read gives the captured state, the second the present one
  task automatic fault_read2(output logic [31:0] first, output logic [31:0] now);
    logic e;
    xfer(1'b0, ADDR_FAULT, 32'h0000_0000, first, e);
    xfer(1'b0, ADDR_FAULT, 32'h0000_0000, now, e);
  endtask

  // boost comes back only by a fresh 0 to 1 write of the enable
  task automatic boost_reenable();
    logic [31:0] d;
    logic e;
    xfer(1'b1, ADDR_CTRL, 32'h0000_0002, d, e);
    xfer(1'b1, ADDR_CTRL, 32'h0000_0003, d, e);
  endtask
endmodule

// ### tb/cpfl_assertions.sv
`timescale 1ns/1ps

// watches the top ports for protection reactions and bus timing
module cpfl_checker
  import cpfl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire cpfl_pkg::cpfl_cmp_t i_cmp,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire cpfl_pkg::cpfl_ctl_t o_ctl,
  input wire logic o_int_n
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  logic [15:0] low_q; // cycles the interrupt has been low
  logic [15:0] low_d;

  // next low count, cleared while the line is high
  always_comb
  begin
    low_d = o_int_n ? 16'h0000 : low_q + 16'h0001;
  end

  // count register
  always_ff @(posedge i_ref_clk)
  begin
    low_q <= i_rst ? 16'h0000 : low_d;
  end

  // 14 steady cycles clear sync plus filter plus output flop with margin
  property p_held(f, r);
    f [*8] ##1 f [*6] |=> r;
  endproperty

  a_inov_stop: assert property (p_held(i_cmp.in_ov, !o_ctl.conv_on))
    else $error("converter on during input overvoltage");
  a_sysov_sink: assert property (p_held(i_cmp.sys_ov, o_ctl.sys_sink && !o_ctl.conv_on))
    else $error("no sink or converter on in system overvoltage");
  a_batov_stop: assert property (p_held(i_cmp.bat_ov, !o_ctl.chg_on))
    else $error("charging on during battery overvoltage");
  a_treg_slow: assert property (p_held(i_cmp.temp_reg && !o_ctl.boost_on,
    o_ctl.chg_reduce && o_ctl.term_block && o_ctl.timer_half))
    else $error("thermal regulation actions missing");
  a_tshut_off: assert property (p_held(i_cmp.temp_shut, !o_ctl.batsw_on))
    else $error("battery switch on above shutdown point");
  a_lowbat_lin: assert property (p_held(i_cmp.bat_below_min && o_ctl.batsw_on,
    o_ctl.batsw_linear))
    else $error("battery switch not linear below minimum");
  a_oc_latch: assert property (p_held(i_cmp.bat_oc, !o_ctl.batsw_on))
    else $error("battery switch on during overcurrent");
  a_vlim_cut: assert property (p_held(i_cmp.in_vlim, o_ctl.chg_reduce))
    else $error("charge current not lowered at input limit");
  a_int_width: assert property ($rose(o_int_n) |-> low_q == INT_PULSE_CYC)
    else $error("interrupt pulse width wrong");
  a_apb_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("apb answer not one wait state and one cycle");

  c_int: cover property (!o_int_n);
  c_sink: cover property (o_ctl.sys_sink);
  c_boost: cover property (o_ctl.boost_on);
  c_linear: cover property (o_ctl.batsw_linear);
endmodule

bind cpfl_top cpfl_checker u_chk (
  .i_ref_clk(i_ref_clk),
  .i_rst(i_rst),
  .i_cmp(i_cmp),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .o_pready(o_pready),
  .o_ctl(o_ctl),
  .o_int_n(o_int_n)
);

// ### tb/cpfl_tb_top.sv
`timescale 1ns/1ps

`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("BAD t=%0t got %0h exp %0h", $time, g, e); \
    end \
  end

module cpfl_tb_top;
  import cpfl_pkg::*;
  logic i_ref_clk;
  logic i_rst;
  cpfl_cmp_t cmp; // raw comparator flags
  cpfl_ctl_t ctl;
  logic psel, penable, pwrite, pready, pslverr, int_n, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rd2;
  int error_cnt = 0;
  int samples_checked = 0;
  int cnt, k;

  cpfl_top DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmp(cmp), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_ctl(ctl),
    .o_int_n(int_n));
  cpfl_host_model u_host (.i_ref_clk(i_ref_clk), .i_pready(pready), .i_prdata(prdata),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata));

  // 50 MHz clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic rd_reg(input logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0000_0000, rd, err);
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd2, err);
  endtask
  // bounded wait for the interrupt line to reach a level
  task automatic wait_int(input logic lvl, input int lim);
    cnt = 0;
    while (int_n !== lvl && cnt < lim)
    begin
      @(posedge i_ref_clk);
      cnt++;
    end
    `CHK(int_n, lvl)
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog past the six full interrupt pulses the tests wait out
  initial
  begin
    cyc(95000);
    error_cnt++;
    conclude();
  end

  initial
  begin
    i_rst = 1'b1;
    cmp = '0;
    cmp.in_present = 1'b1;
    cyc(16);
    i_rst <= 1'b0;
    // the plug-in seen after reset pulses the interrupt once
    wait_int(1'b0, 40);
    wait_int(1'b1, 13000);
    // reset values, unmapped place, read-only fault register
    rd_reg(ADDR_CTRL);
    `CHK(rd, CTRL_RESET)
    rd_reg(12'h00C);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    wr_reg(ADDR_FAULT, 32'h0000_000F);
    rd_reg(ADDR_FAULT);
    `CHK(rd, 32'h0000_0000)
    `CHK({int_n, ctl.conv_on}, 2'b11)
    // input overvoltage; then a second fault while the capture is held
    cmp.in_ov <= 1'b1;
    wait_int(1'b0, 40);
    `CHK(ctl.conv_on, 1'b0)
    k = 1;
    while (int_n === 1'b0 && k < 13000)
    begin
      @(posedge i_ref_clk);
      k += (int_n === 1'b0) ? 1 : 0;
    end
    `CHK(k, INT_PULSE_CYC)
    cmp.bat_ov <= 1'b1;
    cyc(30);
    `CHK(int_n, 1'b1)
    u_host.fault_read2(rd, rd2);
    `CHK(rd[3:0], {2'b00, FAULT_INPUT})
    `CHK(rd2[3:0], {2'b10, FAULT_INPUT})
    cmp.in_ov <= 1'b0;
    cmp.bat_ov <= 1'b0;
    cyc(20);
    `CHK(ctl.conv_on, 1'b1)
    // battery overvoltage
    cmp.bat_ov <= 1'b1;
    wait_int(1'b0, 40);
    `CHK(ctl.chg_on, 1'b0)
    rd_reg(ADDR_FAULT);
    `CHK(rd[FLT_BAT], 1'b1)
    cmp.bat_ov <= 1'b0;
    wait_int(1'b1, 13000);
    // thermal regulation, shutdown and hysteresis
    cmp.temp_reg <= 1'b1;
    cyc(20);
    `CHK({ctl.chg_reduce, ctl.term_block, ctl.timer_half}, 3'b111)
    rd_reg(ADDR_STATUS);
    `CHK(rd[1], 1'b1)
    cmp.temp_shut <= 1'b1;
    wait_int(1'b0, 40);
    `CHK({ctl.conv_on, ctl.batsw_on}, 2'b00)
    rd_reg(ADDR_FAULT);
    `CHK(rd[1:0], FAULT_THERMAL)
    cmp.temp_shut <= 1'b0;
    cyc(20);
    `CHK(ctl.conv_on, 1'b0)
    cmp.temp_cool <= 1'b1;
    cyc(20);
    `CHK(ctl.conv_on, 1'b1)
    cmp.temp_reg <= 1'b0;
    cmp.temp_cool <= 1'b0;
    wait_int(1'b1, 13000);
    // system overvoltage
    cmp.sys_ov <= 1'b1;
    cyc(20);
    `CHK({ctl.sys_sink, ctl.conv_on}, 2'b10)
    cmp.sys_ov <= 1'b0;
    // input limits, interrupt masked by default
    cmp.in_vlim <= 1'b1;
    cyc(20);
    rd_reg(ADDR_STATUS);
    `CHK({rd[4:3], ctl.chg_reduce, int_n}, 4'b0111)
    cmp.in_vlim <= 1'b0;
    cmp.in_ilim <= 1'b1;
    cyc(20);
    rd_reg(ADDR_STATUS);
    `CHK(rd[4:3], 2'b10)
    cmp.in_ilim <= 1'b0;
    // battery below minimum system level
    cmp.bat_below_min <= 1'b1;
    cyc(20);
    rd_reg(ADDR_STATUS);
    `CHK({rd[2], ctl.batsw_linear, ctl.sys_track_min}, 3'b111)
    cmp.bat_below_min <= 1'b0;
    // charge current steps after recovery from a deep discharge
    cmp.bat_short <= 1'b1;
    cmp.bat_low <= 1'b1;
    cyc(20);
    `CHK(ctl.ichg_sel, 2'h2)
    cmp.bat_short <= 1'b0;
    cyc(20);
    `CHK(ctl.ichg_sel, 2'h1)
    cmp.bat_low <= 1'b0;
    // supplement, left on depletion
    cmp.chg_zero <= 1'b1;
    cmp.sys_below_bat <= 1'b1;
    cyc(20);
    rd_reg(ADDR_STATUS);
    `CHK({rd[7], ctl.batsw_on, ctl.batsw_vds_reg}, 3'b111)
    cmp.bat_depl <= 1'b1;
    cyc(20);
    `CHK(ctl.batsw_on, 1'b0)
    cmp.chg_zero <= 1'b0;
    cmp.sys_below_bat <= 1'b0;
    // depletion latch without input, freed by plug-in
    cmp.in_present <= 1'b0;
    cyc(20);
    cmp.bat_depl <= 1'b0;
    cyc(20);
    rd_reg(ADDR_STATUS);
    `CHK({rd[6], ctl.batsw_on}, 2'b10)
    cmp.in_present <= 1'b1;
    cyc(20);
    rd_reg(ADDR_STATUS);
    `CHK(rd[6], 1'b0)
    wait_int(1'b1, 13000);
    // overcurrent latch, freed only by a shipping exit event
    cmp.bat_oc <= 1'b1;
    cyc(20);
    cmp.bat_oc <= 1'b0;
    cyc(20);
    rd_reg(ADDR_STATUS);
    `CHK({rd[5], ctl.batsw_on}, 2'b10)
    cmp.ship_exit <= 1'b1;
    cyc(20);
    cmp.ship_exit <= 1'b0;
    rd_reg(ADDR_STATUS);
    `CHK(rd[5], 1'b0)
    // boost soft start, then a lasting short
    wr_reg(ADDR_CTRL, 32'h0000_0003);
    cyc(20);
    `CHK(ctl.boost_ramp < BOOST_SS_STEPS, 1'b1)
    cmp.boost_short <= 1'b1;
    rd = 32'h0000_0001;
    for (k = 0; k < 1500 && rd[CTRL_BOOST_EN] !== 1'b0; k++)
      rd_reg(ADDR_CTRL);
    cyc(2);
    `CHK({rd[CTRL_BOOST_EN], ctl.boost_on, int_n}, 3'b000)
    rd_reg(ADDR_FAULT);
    `CHK(rd[FLT_BOOST], 1'b1)
    cmp.boost_short <= 1'b0;
    wait_int(1'b1, 13000);
    u_host.boost_reenable();
    rd_reg(ADDR_FAULT);
    `CHK(rd[FLT_BOOST], 1'b0)
    // boost overvoltage once running
    cyc(300);
    cmp.boost_ov <= 1'b1;
    wait_int(1'b0, 40);
    rd_reg(ADDR_CTRL);
    `CHK({rd[CTRL_BOOST_EN], ctl.boost_on}, 2'b00)
    rd_reg(ADDR_FAULT);
    `CHK(rd[FLT_BOOST], 1'b1)
    cmp.boost_ov <= 1'b0;
    cyc(10);
    conclude();
  end
endmodule
